/* hw/fifo_bus_regs.svh */
/*
 * fixed widths, depth, step sizes and reset codes shared by the queue/bus engine.
 * assumes: included by bare name from every design file; guarded against double use.
 */
`ifndef FIFO_BUS_REGS_SVH
`define FIFO_BUS_REGS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define FB_DATA_W 32
`define FB_ADDR_W 32
`define FB_LEN_W 8
`define FB_LEVEL_W 3

// ----------------------------------------------------------------------------
// buffering
// ----------------------------------------------------------------------------
`define FB_FIFO_DEPTH 4

// ----------------------------------------------------------------------------
// steps and reset values
// ----------------------------------------------------------------------------
`define FB_LEN_ONE 8'h01
`define FB_LEN_ZERO 8'h00
`define FB_ADDR_ONE 32'h00000001
`define FB_SYNC_RESET 2'h0

`endif

/* hw/fifo_bus_pkg.sv */
/*
 * types of the queue/bus engine: words, lengths, job modes and controller states.
 * assumes: fifo_bus_regs.svh supplies the widths.
 */
`include "fifo_bus_regs.svh"

package fifo_bus_pkg;

    // ------------------------------------------------------------------------
    // data types
    // ------------------------------------------------------------------------
    typedef logic [`FB_DATA_W-1:0] word_t;
    typedef logic [`FB_ADDR_W-1:0] addr_t;
    typedef logic [`FB_LEN_W-1:0] len_t;
    typedef logic [`FB_LEVEL_W-1:0] level_t;

    // job kinds picked at start
    typedef enum logic [1:0] {
        MODE_COPY = 2'h0,   // input queue -> output queue
        MODE_BUS_RD = 2'h1, // bus reads -> output queue
        MODE_BUS_WR = 2'h2  // input queue -> bus writes
    } job_mode_e;

    // controller states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD_REQ = 4'h2,
        ST_RD_DATA = 4'h4,
        ST_STREAM = 4'h8
    } ctl_state_e;

endpackage : fifo_bus_pkg

/* hw/stream_if.sv */
/*
 * valid/ready word link between the engine and its buffer.
 * assumes: one clock; level is driven by the storing side only.
 */
`timescale 1ns/10ps
`include "fifo_bus_regs.svh"

interface stream_if;
    logic [`FB_DATA_W-1:0] data;  // word in flight
    logic valid;                  // word offered
    logic ready;                  // word accepted
    logic [`FB_LEVEL_W-1:0] level; // words held by the store

    // side that offers words
    modport producer (output data, output valid, input ready, input level);
    // side that takes words
    modport consumer (input data, input valid, output ready, output level);
endinterface : stream_if

/* hw/reset_sync.sv */
/*
 * two-stage release of the asynchronous active-low reset.
 * assumes: reset_n may rise at any time relative to clk.
 */
`timescale 1ns/10ps
`include "fifo_bus_regs.svh"

module reset_sync
(
    // clock and raw reset
    input wire logic clk,
    input wire logic reset_n,
    // released copy
    output logic rst_n
);
    typedef struct packed {
        logic [1:0] sh; // shift stages, only the last is read
    } sync_s;

    sync_s s_r;
    sync_s s_nxt;

    // ------------------------------------------------------------------------
    // next value: shift a one in
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sh = {s_r.sh[0], 1'b1};
    end

    // asserts at once, releases two edges later
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r.sh <= `FB_SYNC_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign rst_n = s_r.sh[1];
endmodule : reset_sync

/* hw/word_fifo.sv */
/*
 * small synchronous word buffer with valid/ready on both sides and a fill level.
 * assumes: one clock, synchronised active-low reset; depth fixed at the shared value.
 */
`timescale 1ns/10ps
`include "fifo_bus_regs.svh"

module word_fifo
#(
    parameter int WIDTH = `FB_DATA_W,
    parameter int DEPTH = `FB_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling and draining sides
    stream_if.consumer wr,
    stream_if.producer rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
        logic [AW-1:0] wp;                // write slot
        logic [AW-1:0] rp;                // read slot
        logic [`FB_LEVEL_W-1:0] cnt;      // words held
    } fifo_s;

    fifo_s s_r;
    fifo_s s_nxt;
    logic push;
    logic pop;

    // honest full and empty straight from the count
    assign wr.ready = s_r.cnt < (`FB_LEVEL_W)'(DEPTH);
    assign wr.level = s_r.cnt;
    assign rd.valid = s_r.cnt != '0;
    assign rd.data = s_r.mem[s_r.rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    // ------------------------------------------------------------------------
    // pointer and count update
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = wr.data;
            s_nxt.wp = (s_r.wp == (AW)'(DEPTH - 1)) ? '0 : s_r.wp + (AW)'(1);
        end
        if (pop)
        begin
            s_nxt.rp = (s_r.rp == (AW)'(DEPTH - 1)) ? '0 : s_r.rp + (AW)'(1);
        end
        s_nxt.cnt = s_r.cnt + (`FB_LEVEL_W)'(push) - (`FB_LEVEL_W)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule : word_fifo

/* hw/queue_bus_engine.sv */
/*
 * queue/bus engine: moves job_len words from a source (input sequential queue port or
 * generic master bus reads) through a four-word buffer to a sink (output sequential
 * queue port or generic master bus writes), in single-access or burst bus form.
 * assumes: the queues and the bus bridge are logic on clk; their flags are sampled at
 * the same edge as the strobes; reset_n is asynchronous and is released here.
 */
// Contract
// - stall reads while input queue is empty
// - read strobe high when word is taken
// - present output word, hold while queue full
// - write strobe high once queue has space
// - last-write pulse after final output write
// - single access: one request per word, address
// - burst: base address, length, consecutive words
// - read request: strobe, direction low, address
// - stall pending read until response arrives
// - ready response read the following cycle
// - blocked write holds address and data
// - write: request strobe and direction high
// - burst read captures length words
// - burst read pauses while responses empty
// - blocked burst write holds base, length, data
// - write valid drops while request queue full
// - burst write ends after length words
`timescale 1ns/10ps
`include "fifo_bus_regs.svh"

module queue_bus_engine
    import fifo_bus_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // job control
    input wire logic start,
    input wire logic [1:0] job_mode,
    input wire logic job_burst,
    input wire addr_t job_addr,
    input wire len_t job_len,
    output logic busy,
    output logic done,
    // input sequential queue port
    input wire logic in_empty_n,
    input wire word_t in_dout,
    output logic in_read,
    // output sequential queue port
    input wire logic out_full_n,
    output logic out_write,
    output word_t out_din,
    output logic out_lwr,
    // generic master bus port, request side
    input wire logic req_full_n,
    output logic req_write,
    output logic req_din,
    output addr_t req_addr,
    output len_t req_size,
    output word_t req_dout,
    // generic master bus port, response side
    input wire logic rsp_empty_n,
    input wire word_t rsp_dout,
    output logic rsp_read
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        ctl_state_e st;   // controller state
        job_mode_e mode;  // job kind latched at start
        logic burst;      // burst form on the bus
        len_t src_rem;    // words still to pull into the buffer
        len_t pop_rem;    // words still to pop from the buffer
        len_t snk_rem;    // words still to hand to the sink
        len_t rsp_pend;   // responses owed by the current request
        addr_t addr;      // bus address on the pins
        logic in_read;    // input queue strobe
        logic out_write;  // output queue strobe
        logic out_lwr;    // last write done
        logic hold;       // word register holds a word
        word_t word;      // word presented to the sink
        logic req_write;  // bus request strobe
        logic req_din;    // bus direction, high for write
        len_t req_size;   // bus length on the pins
        logic rsp_read;   // bus response strobe
        logic busy;       // job running
        logic done;       // job finished pulse
    } ctl_s;

    ctl_s s_r;
    ctl_s s_nxt;
    logic rst_n;        // released reset
    logic take_in;      // input word taken at this edge
    logic take_rsp;     // response word taken at this edge
    logic push;         // word into the buffer
    logic to_bus;       // sink is the bus
    logic acc;          // sink accepts the held word at this edge
    logic pop;          // word from the buffer into the word register
    logic room;         // buffer has a free slot for one more strobe
    level_t lvl_after;  // level once this edge's push lands

    stream_if wr_link ();
    stream_if rd_link ();

    // ------------------------------------------------------------------------
    // reset release and buffer
    // ------------------------------------------------------------------------
    reset_sync u_reset_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .rst_n(rst_n)
    );

    word_fifo #(.WIDTH(`FB_DATA_W), .DEPTH(`FB_FIFO_DEPTH)) u_word_fifo
    (
        .clk(clk),
        .rst_n(rst_n),
        .wr(wr_link.consumer),
        .rd(rd_link.producer)
    );

    // ------------------------------------------------------------------------
    // transfer decisions of this cycle
    // ------------------------------------------------------------------------
    // a strobe only moves a word if the partner's flag is also high now
    assign take_in = s_r.in_read && in_empty_n;
    assign take_rsp = s_r.rsp_read && rsp_empty_n;
    assign push = take_in || take_rsp;
    assign wr_link.valid = push;
    assign wr_link.data = take_rsp ? rsp_dout : in_dout;
    assign to_bus = s_r.mode == MODE_BUS_WR;
    assign acc = s_r.hold && (to_bus ? (s_r.req_write && req_full_n)
                                     : (s_r.out_write && out_full_n));
    assign pop = (!s_r.hold || acc) && (s_r.pop_rem != `FB_LEN_ZERO) && rd_link.valid;
    assign rd_link.ready = pop;
    // strobes are registered, so room is judged with this edge's push counted;
    // pops are ignored, which costs a cycle at full but never drops a word
    assign lvl_after = wr_link.level + level_t'(push);
    assign room = lvl_after < level_t'(`FB_FIFO_DEPTH);

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        // sink side: word register drains to the output queue or the bus
        if (acc)
        begin
            s_nxt.snk_rem = s_r.snk_rem - `FB_LEN_ONE;
            if (to_bus && !s_r.burst)
            begin
                s_nxt.addr = s_r.addr + `FB_ADDR_ONE;
            end
        end
        s_nxt.hold = (s_r.hold && !acc) || pop;
        if (pop)
        begin
            s_nxt.word = rd_link.data;
            s_nxt.pop_rem = s_r.pop_rem - `FB_LEN_ONE;
        end
        // word stays on the pins while the queue is full
        s_nxt.out_write = !to_bus && s_nxt.hold && out_full_n;
        s_nxt.out_lwr = acc && !to_bus && (s_r.snk_rem == `FB_LEN_ONE);
        // bus write: valid follows space, dropped while full, raised again after
        s_nxt.req_write = to_bus && s_nxt.hold && req_full_n;
        s_nxt.req_din = to_bus;
        // source side counting
        if (push)
        begin
            s_nxt.src_rem = s_r.src_rem - `FB_LEN_ONE;
        end
        if (take_rsp)
        begin
            s_nxt.rsp_pend = s_r.rsp_pend - `FB_LEN_ONE;
        end
        case (s_r.st)
            ST_IDLE:
            begin
                if (start)
                begin
                    s_nxt.mode = job_mode_e'(job_mode);
                    s_nxt.burst = job_burst;
                    s_nxt.addr = job_addr;
                    s_nxt.src_rem = job_len;
                    s_nxt.pop_rem = job_len;
                    s_nxt.snk_rem = job_len;
                    // burst carries the whole length, single access one word
                    s_nxt.req_size = job_burst ? job_len : `FB_LEN_ONE;
                    if (job_len == `FB_LEN_ZERO)
                    begin
                        s_nxt.done = 1'b1;
                    end
                    else if (job_mode_e'(job_mode) == MODE_BUS_RD)
                    begin
                        s_nxt.st = ST_RD_REQ;
                        s_nxt.busy = 1'b1;
                        s_nxt.req_write = 1'b1;
                        s_nxt.req_din = 1'b0;
                    end
                    else
                    begin
                        // bus writes rely on the bridge taking the whole burst
                        s_nxt.st = ST_STREAM;
                        s_nxt.busy = 1'b1;
                    end
                end
            end
            ST_RD_REQ:
            begin
                // request held with address and size until the bridge has space
                if (s_r.req_write && req_full_n)
                begin
                    s_nxt.st = ST_RD_DATA;
                    s_nxt.rsp_pend = s_r.req_size;
                end
                else
                begin
                    s_nxt.req_write = 1'b1;
                end
            end
            ST_RD_DATA:
            begin
                // all responses of this request in: next single read or drain
                if (s_nxt.rsp_pend == `FB_LEN_ZERO)
                begin
                    if (s_nxt.src_rem != `FB_LEN_ZERO)
                    begin
                        s_nxt.st = ST_RD_REQ;
                        s_nxt.req_write = 1'b1;
                        s_nxt.addr = s_r.addr + `FB_ADDR_ONE;
                    end
                    else
                    begin
                        s_nxt.st = ST_STREAM;
                    end
                end
            end
            ST_STREAM:
            begin
                if (s_nxt.snk_rem == `FB_LEN_ZERO)
                begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                end
            end
            default:
            begin
                // illegal code: fall back to idle, input and response strobes quiet
                s_nxt.st = ST_IDLE;
                s_nxt.busy = 1'b0;
            end
        endcase
        // input strobe: only with data flagged, words owed and buffer room
        s_nxt.in_read = (s_nxt.st == ST_STREAM) && (s_nxt.mode != MODE_BUS_RD) &&
                        (s_nxt.src_rem != `FB_LEN_ZERO) && in_empty_n && room;
        // response strobe: the cycle after the request or as soon as data shows
        s_nxt.rsp_read = (s_nxt.st == ST_RD_DATA) && (s_nxt.rsp_pend != `FB_LEN_ZERO) &&
                         rsp_empty_n && room;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign busy = s_r.busy;
    assign done = s_r.done;
    assign in_read = s_r.in_read;
    assign out_write = s_r.out_write;
    assign out_din = s_r.word;
    assign out_lwr = s_r.out_lwr;
    assign req_write = s_r.req_write;
    assign req_din = s_r.req_din;
    assign req_addr = s_r.addr;
    assign req_size = s_r.req_size;
    assign req_dout = s_r.word;
    assign rsp_read = s_r.rsp_read;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    AST_IN_STALL: assert property (@(posedge clk) disable iff (!rst_n)
        in_read |-> $past(in_empty_n))
        else $error("input strobe raised after empty flag");

    AST_IN_TAKE: assert property (@(posedge clk) disable iff (!rst_n)
        (in_read && in_empty_n) |-> wr_link.ready)
        else $error("input word taken with no buffer room");

    AST_OUT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.hold && !to_bus && !out_full_n) |=> (s_r.hold && $stable(out_din)))
        else $error("output word not held while queue full");

    AST_OUT_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.hold && !to_bus && !acc && out_full_n) |=> out_write)
        else $error("output strobe missing with space present");

    AST_LWR_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        out_lwr |-> (done && !busy))
        else $error("last-write pulse not at end of job");

    AST_SINGLE_SIZE: assert property (@(posedge clk) disable iff (!rst_n)
        (req_write && !s_r.burst) |-> (req_size == `FB_LEN_ONE))
        else $error("single access with size other than one");

    AST_RD_REQ_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (req_write && !req_din && !req_full_n) |=>
            (req_write && !req_din && $stable(req_addr) && $stable(req_size)))
        else $error("read request dropped or changed while blocked");

    AST_RSP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        rsp_read |-> ($past(rsp_empty_n) && (s_r.st == ST_RD_DATA)))
        else $error("response strobe without data flagged");

    AST_RSP_NEXT: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == ST_RD_REQ && req_write && req_full_n && rsp_empty_n && room) |=> rsp_read)
        else $error("ready response not read the following cycle");

    AST_WR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (to_bus && s_r.hold && !req_full_n) |=>
            ($stable(req_dout) && $stable(req_addr) && !req_write))
        else $error("blocked write changed address or data");

    AST_WR_DIR: assert property (@(posedge clk) disable iff (!rst_n)
        (req_write && to_bus) |-> (req_din && s_r.hold))
        else $error("write strobe without direction or data");

    AST_BURST_END: assert property (@(posedge clk) disable iff (!rst_n)
        acc |-> (s_r.snk_rem != `FB_LEN_ZERO))
        else $error("sink accepted more words than the length");

    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == ST_IDLE) |-> !(in_read || out_write || req_write || rsp_read))
        else $error("strobe raised while idle");
endmodule : queue_bus_engine

/* verification/far_side_model.sv */
/*
 * far side model: input queue, output queue and a bus bridge with request/response queues.
 * assumes: same clock as the engine; the bench sets the stall knobs just after the edge.
 */
`timescale 1ns/10ps

module far_side_model
    import fifo_bus_pkg::*;
(
    // clock and stall knobs: in, out, req, rsp
    input wire logic clk,
    input wire logic [3:0] stall,
    // sequential queue ports
    output logic in_empty_n,
    output word_t in_dout,
    input wire logic in_read,
    output logic out_full_n,
    // bus bridge
    output logic req_full_n,
    input wire logic req_write,
    input wire logic req_din,
    input wire addr_t req_addr,
    input wire len_t req_size,
    output logic rsp_empty_n,
    output word_t rsp_dout,
    input wire logic rsp_read
);
    word_t src_r = 32'h00000100; // next source word
    word_t head_r = 32'h00000000; // front response word
    logic have_r = 1'b0; // responses waiting
    word_t rsp_q[$]; // unbounded, so every burst read fits

    // released data lines show the inverse, never a stale word
    assign in_empty_n = ~stall[0];
    assign in_dout = in_empty_n ? src_r : ~src_r;
    assign out_full_n = ~stall[1];
    assign req_full_n = ~stall[2];
    assign rsp_empty_n = ~stall[3] && have_r;
    assign rsp_dout = rsp_empty_n ? head_r : ~head_r;

    // a strobe moves a word only with its own flag high
    always @(posedge clk)
    begin
        if (in_read && in_empty_n) src_r <= src_r + 32'h00000001;
        if (rsp_read && rsp_empty_n) void'(rsp_q.pop_front());
        // read answers carry their own address, so data shows where it came from
        if (req_write && req_full_n && !req_din)
        begin
            for (int i = 0; i < int'(req_size); i++) rsp_q.push_back(req_addr + 32'(i));
        end
        have_r <= rsp_q.size() != 0;
        head_r <= (rsp_q.size() != 0) ? rsp_q[0] : 32'h00000000;
    end
endmodule : far_side_model

/* verification/testbench.sv */
/*
 * testbench: copy, bus read and bus write jobs with periodic stalls on every flag.
 * assumes: design files compiled first; one 20 MHz clock.
 */
`timescale 1ns/10ps

module testbench
    import fifo_bus_pkg::*;
;
    logic clk, reset_n, start, job_burst, busy, done, in_empty_n, in_read, out_full_n;
    logic out_write, out_lwr, req_full_n, req_write, req_din, rsp_empty_n, rsp_read;
    logic [1:0] job_mode;
    logic [3:0] stall_en;
    logic [3:0] stall = 4'h0; // stall knobs, written only by the stall process
    logic [3:0] tick = 4'h0; // free-running spell counter
    addr_t job_addr, req_addr;
    len_t job_len, req_size;
    word_t in_dout, out_din, req_dout, rsp_dout, src_exp;
    word_t got[$]; // words seen leaving the engine
    addr_t adr[$]; // addresses of write beats
    int nreq, nlwr, mismatches, checks;

    queue_bus_engine queue_bus_engine_i (.clk, .reset_n, .start, .job_mode, .job_burst,
        .job_addr, .job_len, .busy, .done, .in_empty_n, .in_dout, .in_read, .out_full_n,
        .out_write, .out_din, .out_lwr, .req_full_n, .req_write, .req_din, .req_addr,
        .req_size, .req_dout, .rsp_empty_n, .rsp_dout, .rsp_read);
    far_side_model far_side_model_i (.clk, .stall, .in_empty_n, .in_dout, .in_read,
        .out_full_n, .req_full_n, .req_write, .req_din, .req_addr, .req_size, .rsp_empty_n,
        .rsp_dout, .rsp_read);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // stalls come and go in two-cycle (out, rsp) and four-cycle (in, req) spells so every wait is hit mid-job
    always @(posedge clk)
    begin
        #1 tick = tick + 4'h1;
        stall = stall_en & {tick[1], tick[2], tick[1], tick[2]};
    end

    // monitor: record accepted transfers
    always @(posedge clk)
    begin
        if (out_write && out_full_n) got.push_back(out_din);
        if (req_write && req_full_n)
        begin
            check(32'(req_size), job_burst ? 32'(job_len) : 32'h1);
            if (req_din) got.push_back(req_dout);
            if (req_din) adr.push_back(req_addr);
            if (!req_din) nreq++;
        end
        if (out_lwr === 1'b1) nlwr++;
    end

    task automatic check(input word_t seen, input word_t exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    // one job, bounded wait for done, then judge words and addresses
    task automatic run_job(input logic [1:0] m, input logic b, input addr_t a, input len_t n,
        input logic [3:0] st);
        int k;
        got.delete();
        adr.delete();
        {nreq, nlwr, stall_en} = '0;
        {job_mode, job_burst, job_addr, job_len, start} = {m, b, a, n, 1'b1};
        @(posedge clk);
        #1 start = 1'b0;
        stall_en = st;
        for (k = 0; k < 500 && done !== 1'b1; k++) @(posedge clk) #1;
        // done is a one-cycle pulse: judge it, and busy dropping, while it stands
        check(32'({done === 1'b1, busy}), 32'h2);
        @(posedge clk);
        #1 stall_en = 4'h0;
        check(32'(got.size()), 32'(n));
        for (k = 0; k < got.size(); k++)
        begin
            check(got[k], (m == 2'h1) ? a + 32'(k) : src_exp + 32'(k));
            if (m == 2'h2) check(adr[k], b ? a : a + 32'(k));
        end
        if (m != 2'h1) src_exp = src_exp + 32'(n);
    endtask : run_job

    task automatic quiet_after_reset();
        repeat (4) @(posedge clk) #1 check(32'({in_read, out_write, req_write, rsp_read}), 0);
    endtask : quiet_after_reset

    task automatic copy_with_stalls();
        run_job(2'h0, 1'b0, 32'h00000000, 8'h05, 4'h3);
        check(32'(nlwr), 32'h1);
    endtask : copy_with_stalls

    task automatic single_reads();
        run_job(2'h1, 1'b0, 32'h00002000, 8'h03, 4'hE);
        check(32'(nreq), 32'h3);
    endtask : single_reads

    task automatic burst_read();
        run_job(2'h1, 1'b1, 32'h00003000, 8'h06, 4'hC);
        check(32'(nreq), 32'h1);
    endtask : burst_read

    task automatic bus_writes();
        run_job(2'h2, 1'b0, 32'h00004000, 8'h03, 4'h5);
        run_job(2'h2, 1'b1, 32'h00005000, 8'h05, 4'h5);
        check(32'(nreq), 32'h0);
    endtask : bus_writes

    // spare mode code runs as a copy; an empty job only pulses done
    task automatic spare_mode_and_empty_job();
        run_job(2'h3, 1'b0, 32'h00000000, 8'h02, 4'h3);
        check(32'(nlwr), 32'h1);
        run_job(2'h0, 1'b0, 32'h00000000, 8'h00, 4'h0);
        check(32'(nlwr), 32'h0);
    endtask : spare_mode_and_empty_job

    task automatic test_done();
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        {reset_n, start, job_mode, job_burst, job_addr, job_len, stall_en} = '0;
        {mismatches, checks} = '0;
        src_exp = 32'h00000100;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        quiet_after_reset();
        copy_with_stalls();
        single_reads();
        burst_read();
        bus_writes();
        spare_mode_and_empty_job();
        test_done();
    end

    // watchdog: seven jobs need far fewer than 8000 cycles
    initial
    begin
        #(50 * 8000);
        mismatches++;
        test_done();
    end
endmodule : testbench
